/* File: hdl/tdbg_lane.sv */
`timescale 1ns/1ns
`default_nettype none
module tdbg_lane (
  input wire logic clk,
  input wire logic reset_n,
  tdbg_lane_if.core lane
);
  // ----------------------------------------
  // equalizer datapath selection
  // ----------------------------------------
  assign lane.fb_path = (lane.eq_sel == tdbg_pkg::EQ_FEEDBACK);
  assign lane.lin_path = (lane.eq_sel == tdbg_pkg::EQ_LINEAR);
  assign lane.eq_path_reset = lane.eq_reset;

  // ----------------------------------------
  // transmit path: inhibit and error inject
  // ----------------------------------------
  wire logic [7:0] injected;
  wire logic [7:0] next_tx_out;
  assign injected = lane.force_err ? ~lane.tx_in : lane.tx_in;
  assign next_tx_out = lane.tx_block ? tdbg_pkg::FILL_WORD : injected;
  logic [7:0] tx_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tx_q <= tdbg_pkg::FILL_WORD;
    else tx_q <= next_tx_out;
  end
  assign lane.tx_out = tx_q;

  // ----------------------------------------
  // receive checker: live flag and counter
  // ----------------------------------------
  wire logic mismatch;
  assign mismatch = lane.rx_valid && (lane.rx_in != lane.rx_expect);
  logic err_q;
  logic [15:0] cnt;
  wire logic [15:0] next_cnt;
  assign next_cnt = lane.cnt_clear ? tdbg_pkg::CNT_ZERO :
    (mismatch && cnt != tdbg_pkg::CNT_MAX) ? cnt + tdbg_pkg::CNT_ONE : cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= 1'h0;
      cnt <= tdbg_pkg::CNT_ZERO;
    end else begin
      err_q <= mismatch;
      cnt <= next_cnt;
    end
  end
  assign lane.prbs_err = err_q;
  assign lane.err_count = cnt;

  chk_err_live: assert property (@(posedge clk) disable iff (!reset_n)
    !mismatch |=> !err_q) else $error("error flag stuck");
  chk_cnt_clear: assert property (@(posedge clk) disable iff (!reset_n)
    lane.cnt_clear |=> cnt == tdbg_pkg::CNT_ZERO) else $error("no clear");
  chk_tx_block: assert property (@(posedge clk) disable iff (!reset_n)
    lane.tx_block |=> tx_q == tdbg_pkg::FILL_WORD) else $error("tx leaks");
  chk_force_err: assert property (@(posedge clk) disable iff (!reset_n)
    lane.force_err && !lane.tx_block |=> tx_q == ~$past(lane.tx_in))
    else $error("no inject");
endmodule
`default_nettype wire

/* File: hdl/tdbg_status.sv */
`timescale 1ns/1ns
`default_nettype none
module tdbg_status (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] rx_equalizer_select,
  input wire logic [1:0] rx_equalizer_reset,
  input wire logic [1:0] tx_lane_block,
  input wire logic [1:0] rx_prbs_counter_clear,
  input wire logic [7:0] rx_prbs_pattern_select,
  input wire logic [7:0] tx_prbs_pattern_select,
  input wire logic [1:0] tx_prbs_error_inject,
  input wire logic [15:0] tx_pattern_in,
  input wire logic [15:0] rx_pattern_expect,
  input wire logic [15:0] rx_pattern_in,
  input wire logic [1:0] rx_pattern_valid,
  input wire logic [7:0] rx_disparity_raw,
  input wire logic [7:0] rx_code_raw,
  input wire logic [1:0] rx_comma_raw,
  input wire logic rx_align_raw,
  input wire logic [3:0] rx_sync_raw,
  input wire logic tx_phase_done_raw,
  output logic [15:0] tx_pattern_out,
  output logic [1:0] decision_feedback_path,
  output logic [1:0] low_power_linear_path,
  output logic [1:0] rx_equalizer_path_reset,
  output logic [7:0] rx_prbs_sel_out,
  output logic [7:0] tx_prbs_sel_out,
  output logic [1:0] rx_prbs_error_flag,
  output logic [31:0] rx_prbs_error_count,
  output logic [7:0] rx_byte_disparity_error,
  output logic [7:0] rx_byte_code_violation,
  output logic [1:0] rx_comma_seen,
  output logic [5:0] debug
);
  // ----------------------------------------
  // async control inputs: two-stage sync
  // ----------------------------------------
  logic [1:0] eqs_a, eqs_b, eqr_a, eqr_b;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eqs_a <= 2'h0;
      eqs_b <= 2'h0;
      eqr_a <= 2'h0;
      eqr_b <= 2'h0;
    end else begin
      eqs_a <= rx_equalizer_select;
      eqs_b <= eqs_a;
      eqr_a <= rx_equalizer_reset;
      eqr_b <= eqr_a;
    end
  end

  // ----------------------------------------
  // pattern selects, registered
  // ----------------------------------------
  logic [7:0] rx_sel_q, tx_sel_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sel_q <= 8'h00;
      tx_sel_q <= 8'h00;
    end else begin
      rx_sel_q <= rx_prbs_pattern_select;
      tx_sel_q <= tx_prbs_pattern_select;
    end
  end
  assign rx_prbs_sel_out = rx_sel_q;
  assign tx_prbs_sel_out = tx_sel_q;

  // ----------------------------------------
  // per-lane engines
  // ----------------------------------------
  for (genvar i = 0; i < tdbg_pkg::LANES; i++) begin : g_lane
    tdbg_lane_if lif ();
    localparam int SB = i * tdbg_pkg::SEL_PER_LANE;
    localparam int DB = i * 8;
    assign lif.eq_sel = eqs_b[i];
    assign lif.eq_reset = eqr_b[i];
    assign lif.tx_block = tx_lane_block[i];
    assign lif.cnt_clear = rx_prbs_counter_clear[i];
    assign lif.force_err = tx_prbs_error_inject[i];
    assign lif.rx_sel = rx_sel_q[SB +: 4];
    assign lif.tx_sel = tx_sel_q[SB +: 4];
    assign lif.tx_in = tx_pattern_in[DB +: 8];
    assign lif.rx_expect = rx_pattern_expect[DB +: 8];
    assign lif.rx_in = rx_pattern_in[DB +: 8];
    assign lif.rx_valid = rx_pattern_valid[i];
    tdbg_lane u_lane (
      .clk(clk),
      .reset_n(reset_n),
      .lane(lif.core)
    );
    assign tx_pattern_out[DB +: 8] = lif.tx_out;
    assign decision_feedback_path[i] = lif.fb_path;
    assign low_power_linear_path[i] = lif.lin_path;
    assign rx_equalizer_path_reset[i] = lif.eq_path_reset;
    assign rx_prbs_error_flag[i] = lif.prbs_err;
    assign rx_prbs_error_count[i*tdbg_pkg::CNT_W +: tdbg_pkg::CNT_W] =
      lif.err_count;
  end

  // ----------------------------------------
  // receive byte status and comma
  // ----------------------------------------
  logic [7:0] disp_q, code_q;
  logic [1:0] comma_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_q <= 8'h00;
      code_q <= 8'h00;
      comma_q <= 2'h0;
    end else begin
      disp_q <= rx_disparity_raw;
      code_q <= rx_code_raw;
      comma_q <= rx_comma_raw;
    end
  end
  assign rx_byte_disparity_error = disp_q;
  assign rx_byte_code_violation = code_q;
  assign rx_comma_seen = comma_q;

  // ----------------------------------------
  // debug vector: async status synchronised
  // ----------------------------------------
  logic [5:0] dbg_a, dbg_b;
  wire logic [5:0] dbg_raw;
  assign dbg_raw = {rx_align_raw, rx_sync_raw, tx_phase_done_raw};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dbg_a <= 6'h00;
      dbg_b <= 6'h00;
    end else begin
      dbg_a <= dbg_raw;
      dbg_b <= dbg_a;
    end
  end
  assign debug = dbg_b;

  chk_eq_select: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 ##2 low_power_linear_path == $past(rx_equalizer_select, 2) &&
    decision_feedback_path == ~low_power_linear_path)
    else $error("path select broken");
  chk_eq_reset: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 ##2 rx_equalizer_path_reset == $past(rx_equalizer_reset, 2))
    else $error("eq reset wrong");
  chk_disp_byte: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> rx_byte_disparity_error == $past(rx_disparity_raw))
    else $error("disparity lag");
  chk_code_byte: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> rx_byte_code_violation == $past(rx_code_raw))
    else $error("code lag");
  chk_align_bit: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 ##2 debug[tdbg_pkg::DBG_ALIGN] == $past(rx_align_raw, 2))
    else $error("align lag");
  chk_sync_bits: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 ##2 debug[4:1] == $past(rx_sync_raw, 2))
    else $error("sync lag");
endmodule
`default_nettype wire

/* File: shared/tdbg_lane_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tdbg_lane_if;
  logic eq_sel;
  logic eq_reset;
  logic tx_block;
  logic cnt_clear;
  logic force_err;
  logic [3:0] rx_sel;
  logic [3:0] tx_sel;
  logic [7:0] tx_in;
  logic [7:0] tx_out;
  logic [7:0] rx_expect;
  logic [7:0] rx_in;
  logic rx_valid;
  logic fb_path;
  logic lin_path;
  logic eq_path_reset;
  logic prbs_err;
  logic [15:0] err_count;
  modport core (input eq_sel, eq_reset, tx_block, cnt_clear, force_err,
    rx_sel, tx_sel, tx_in, rx_expect, rx_in, rx_valid,
    output tx_out, fb_path, lin_path, eq_path_reset, prbs_err, err_count);
  modport top (output eq_sel, eq_reset, tx_block, cnt_clear, force_err,
    rx_sel, tx_sel, tx_in, rx_expect, rx_in, rx_valid,
    input tx_out, fb_path, lin_path, eq_path_reset, prbs_err, err_count);
endinterface
`default_nettype wire

/* File: shared/tdbg_pkg.sv */
package tdbg_pkg;
  // ----------------------------------------
  // widths and field positions
  // ----------------------------------------
  localparam int LANES = 2;
  localparam int BYTES = 8;
  localparam int BYTES_PER_LANE = 4;
  localparam int LOGICAL_LANES = 4;
  localparam int SEL_W = 8;
  localparam int SEL_PER_LANE = 4;
  localparam int DBG_W = 6;
  localparam int DBG_ALIGN = 5;
  localparam int DBG_SYNC_LO = 1;
  localparam int DBG_TXPH = 0;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // equalizer path codes and transmit fill word
  localparam logic EQ_FEEDBACK = 1'h0;
  localparam logic EQ_LINEAR = 1'h1;
  localparam logic [7:0] FILL_WORD = 8'h00;
endpackage

/* File: tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset_n, align, txph;
  logic [1:0] eq_sel, eq_rst, blk, clr, inj, vld, comma, bad, fb, lin;
  logic [1:0] prst, flag, seen;
  logic [3:0] sync;
  logic [7:0] rsel, tsel, disp, code, rsel_o, tsel_o, disp_o, code_o;
  logic [15:0] tx_in, tx_out, exp_w, in_w;
  logic [31:0] cnt;
  logic [5:0] debug;
  int n_errors = 0;
  int samples_checked = 0;
  tdbg_fabric tdbg_fabric_i (.clk(clk), .reset_n(reset_n), .bad(bad),
    .rx_pattern_expect(exp_w), .rx_pattern_in(in_w), .rx_pattern_valid(vld));
  tdbg_status tdbg_status_i (.clk(clk), .reset_n(reset_n),
    .rx_equalizer_select(eq_sel), .rx_equalizer_reset(eq_rst),
    .tx_lane_block(blk), .rx_prbs_counter_clear(clr),
    .rx_prbs_pattern_select(rsel), .tx_prbs_pattern_select(tsel),
    .tx_prbs_error_inject(inj), .tx_pattern_in(tx_in),
    .rx_pattern_expect(exp_w), .rx_pattern_in(in_w),
    .rx_pattern_valid(vld), .rx_disparity_raw(disp), .rx_code_raw(code),
    .rx_comma_raw(comma), .rx_align_raw(align), .rx_sync_raw(sync),
    .tx_phase_done_raw(txph), .tx_pattern_out(tx_out),
    .decision_feedback_path(fb), .low_power_linear_path(lin),
    .rx_equalizer_path_reset(prst), .rx_prbs_sel_out(rsel_o),
    .tx_prbs_sel_out(tsel_o), .rx_prbs_error_flag(flag),
    .rx_prbs_error_count(cnt), .rx_byte_disparity_error(disp_o),
    .rx_byte_code_violation(code_o), .rx_comma_seen(seen), .debug(debug));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_equalizer();
    logic [1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      @(posedge clk);
      eq_sel <= v;
      eq_rst <= v;
      settle(4);
      chk(32'(fb), 32'(v ^ 2'h3));
      chk(32'(lin), 32'(v));
      chk(32'(prst), 32'(v));
    end
  endtask
  task automatic t_tx();
    logic [1:0] b[6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    logic [1:0] f[6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1};
    logic [15:0] e[6] = '{16'hA55A, 16'hA500, 16'h005A, 16'h5A5A,
      16'h5A5A, 16'hA5A5};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      tx_in <= 16'hA55A;
      blk <= b[i];
      inj <= f[i];
      settle(1);
      chk(32'(tx_out), 32'(e[i]));
    end
  endtask
  task automatic t_prbs(input int ln);
    logic [1:0] m;
    m = 2'(1 << ln);
    @(posedge clk);
    bad <= m;
    @(posedge clk);
    bad <= 2'h0;
    #1;
    chk(32'(flag), 32'(m));
    chk(cnt, 32'h1 << (16 * ln));
    settle(1);
    chk(32'(flag), 32'h0);
    @(posedge clk);
    clr <= m;
    @(posedge clk);
    clr <= 2'h0;
    #1;
    chk(cnt, 32'h0);
  endtask
  task automatic t_status();
    @(posedge clk);
    rsel <= 8'h5A;
    tsel <= 8'hC3;
    disp <= 8'h81;
    code <= 8'h3C;
    comma <= 2'h2;
    align <= 1'b1;
    sync <= 4'hA;
    txph <= 1'b1;
    settle(1);
    chk(32'({rsel_o, tsel_o}), 32'h5AC3);
    chk(32'({disp_o, code_o}), 32'h813C);
    chk(32'(seen), 32'h2);
    settle(3);
    chk(32'(debug), 32'h35);
    @(posedge clk);
    align <= 1'b0;
    sync <= 4'h5;
    txph <= 1'b0;
    settle(4);
    chk(32'(debug), 32'h0A);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    {eq_sel, eq_rst, blk, clr, inj, comma, bad} = '0;
    {rsel, tsel, disp, code, sync, align, txph, tx_in} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk(32'({fb, lin}), 32'hC);
    t_equalizer();
    t_tx();
    t_prbs(0);
    t_prbs(1);
    t_status();
    summarize();
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire

/* File: tb/tdbg_fabric.sv */
`timescale 1ns/1ns
`default_nettype none
module tdbg_fabric (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] bad,
  output logic [15:0] rx_pattern_expect,
  output logic [15:0] rx_pattern_in,
  output logic [1:0] rx_pattern_valid
);
  // ----------------------------------------
  // running pattern, corrupted per lane on command
  // ----------------------------------------
  logic [15:0] pattern;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern <= 16'h0000;
      rx_pattern_valid <= 2'h0;
    end else begin
      pattern <= pattern + 16'h0301;
      rx_pattern_valid <= 2'h3;
    end
  end
  assign rx_pattern_expect = pattern;
  assign rx_pattern_in = pattern ^ {{8{bad[1]}}, {8{bad[0]}}};
endmodule
`default_nettype wire
